//--- shc_params.svh
/*
  Register indices, field positions, reset values and fixed counts for the
  sensor hub configuration block.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef SHC_PARAMS_SVH
`define SHC_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define SHC_IDX_MASTER_CFG    8'h14
`define SHC_IDX_S1_TARGET     8'h15
`define SHC_IDX_S1_PTR        8'h16
`define SHC_IDX_S2_TARGET     8'h18
`define SHC_IDX_S2_PTR        8'h19
`define SHC_IDX_S2_CFG        8'h1A
`define SHC_IDX_S3_TARGET     8'h1B
`define SHC_IDX_S3_PTR        8'h1C
`define SHC_IDX_S3_CFG        8'h1D
`define SHC_IDX_S4_TARGET     8'h1E
`define SHC_IDX_S4_PTR        8'h1F
`define SHC_IDX_S1_WDATA      8'h21
`define SHC_IDX_STATUS        8'h22

// ****************************************
// Field positions
// ****************************************
`define SHC_MC_WRONCE_BIT     6
`define SHC_MC_ON_BIT         2
`define SHC_CFG_BATCH_BIT     3
`define SHC_STAT_WRDONE_BIT   7
`define SHC_STAT_NACK_LSB     3
`define SHC_STAT_DONE_BIT     0

// ****************************************
// Reset values and fixed counts
// ****************************************
`define SHC_RST_BYTE          8'h00
`define SHC_S4_READS          3'h1

`endif

//--- shc_pkg.sv
/*
  Types shared by the sensor hub configuration block.
  Assumes no other package; users refer to names with shc_pkg::.
*/
`default_nettype none
package shc_pkg;

  // Sequencer states
  typedef enum logic [1:0] {SHC_IDLE, SHC_SCAN, SHC_WAIT} shc_state_t;

  // One transaction request towards the two-wire engine
  typedef struct packed {
    logic [1:0] slot;
    logic [6:0] addr;
    logic [7:0] reg_ptr;
    logic       read;
    logic [2:0] count;
    logic [7:0] wdata;
    logic       fifo_batch;
  } shc_req_t;

  // AHB-Lite address phase kept for the data phase
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
  } shc_aphase_t;

  // Whole state of the block
  typedef struct packed {
    logic                  master_on;
    logic                  first_cycle_write_only;
    logic [1:0]            external_sensor_count;
    logic [3:0][6:0]       addr;
    logic [3:0]            rd_en;
    logic [3:0][7:0]       reg_ptr;
    logic [3:0][2:0]       read_count;
    logic [3:0]            fifo_batch;
    logic [7:0]            sensor1_write_byte;
    logic                  single_write_complete;
    logic [3:0]            noack;
    logic                  hub_cycle_done;
    logic                  first_cycle_seen;
    shc_state_t            fsm;
    logic [1:0]            slot;
    shc_req_t              req;
    logic                  ap_valid;
    shc_aphase_t           ap;
    logic [31:0]           rdata;
  } shc_regs_t;

endpackage : shc_pkg

`default_nettype wire

//--- shc_hub_cfg.sv
/*
  Sensor hub configuration and status: AHB-Lite register slave plus the
  hub cycle sequencer that issues one request per active sensor slot.
  Assumes the two-wire engine and the data-rate trigger run on hclk and
  that the engine pulses xfer_done once per accepted request.
*/
`timescale 1ns/1ns
`default_nettype none
`include "shc_params.svh"

module shc_hub_cfg (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Hub cycle trigger from the data-rate logic
  input  wire logic              hub_trigger,
  // Request towards the two-wire engine
  output logic                   aux_master_en,
  output logic                   req_valid,
  output shc_pkg::shc_req_t      req,
  // Completion from the two-wire engine
  input  wire logic              xfer_done,
  input  wire logic              xfer_noack
);

  shc_pkg::shc_regs_t s_q;
  shc_pkg::shc_regs_t s_d;

  // ****************************************
  // Helper functions
  // ****************************************

  // Per-sensor config byte: batch bit and read count, upper bits read zero
  function automatic logic [7:0] cfg_byte(input logic batch, input logic [2:0] cnt);
    logic [7:0] v;
    v = `SHC_RST_BYTE;
    v[`SHC_CFG_BATCH_BIT] = batch;
    v[2:0] = cnt;
    return v;
  endfunction : cfg_byte

  // Register read mux, index based
  function automatic logic [7:0] reg_read(input shc_pkg::shc_regs_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = `SHC_RST_BYTE;
    case (idx)
      `SHC_IDX_MASTER_CFG:
      begin
        v[`SHC_MC_WRONCE_BIT] = s.first_cycle_write_only;
        v[`SHC_MC_ON_BIT]     = s.master_on;
        v[1:0]                = s.external_sensor_count;
      end
      `SHC_IDX_S1_TARGET:
      begin
        v = {s.addr[0], s.rd_en[0]};
      end
      `SHC_IDX_S1_PTR:
      begin
        v = s.reg_ptr[0];
      end
      `SHC_IDX_S2_TARGET:
      begin
        v = {s.addr[1], s.rd_en[1]};
      end
      `SHC_IDX_S2_PTR:
      begin
        v = s.reg_ptr[1];
      end
      `SHC_IDX_S2_CFG:
      begin
        v = cfg_byte(s.fifo_batch[1], s.read_count[1]);
      end
      `SHC_IDX_S3_TARGET:
      begin
        v = {s.addr[2], s.rd_en[2]};
      end
      `SHC_IDX_S3_PTR:
      begin
        v = s.reg_ptr[2];
      end
      `SHC_IDX_S3_CFG:
      begin
        v = cfg_byte(s.fifo_batch[2], s.read_count[2]);
      end
      `SHC_IDX_S4_TARGET:
      begin
        v = {s.addr[3], s.rd_en[3]};
      end
      `SHC_IDX_S4_PTR:
      begin
        v = s.reg_ptr[3];
      end
      `SHC_IDX_S1_WDATA:
      begin
        v = s.sensor1_write_byte;
      end
      `SHC_IDX_STATUS:
      begin
        v[`SHC_STAT_WRDONE_BIT]                      = s.single_write_complete;
        v[`SHC_STAT_NACK_LSB+3:`SHC_STAT_NACK_LSB]   = s.noack;
        v[`SHC_STAT_DONE_BIT]                        = s.hub_cycle_done;
        // Bits 2 and 1 stay zero from the default above
      end
      default:
      begin
        v = `SHC_RST_BYTE;
      end
    endcase
    return v;
  endfunction : reg_read

  // Whether a slot takes part in this hub cycle
  function automatic logic slot_active(input shc_pkg::shc_regs_t s, input logic [1:0] slot);
    logic act;
    act = 1'b0;
    if (slot == 2'd0)
    begin
      // Read mode always runs; write mode may be limited to the first cycle
      act = s.rd_en[0] | ~(s.first_cycle_write_only & s.first_cycle_seen);
    end
    else
    begin
      act = s.rd_en[slot];
    end
    return act;
  endfunction : slot_active

  // Whether the current slot is the last one the sensor count allows
  function automatic logic last_slot(input shc_pkg::shc_regs_t s);
    return s.slot == s.external_sensor_count;
  endfunction : last_slot

  // ****************************************
  // Next-state logic
  // ****************************************

  // Bus writes, sequencer, status flags, then read data from the new state
  always_comb
  begin
    logic [7:0] wb;
    logic       start;
    s_d   = s_q;
    wb    = hwdata[7:0];
    start = 1'b0;

    // Data phase of a write lands in the register picked at address phase
    if (s_q.ap_valid && s_q.ap.wr)
    begin
      case (s_q.ap.idx)
        `SHC_IDX_MASTER_CFG:
        begin
          s_d.first_cycle_write_only = wb[`SHC_MC_WRONCE_BIT];
          s_d.master_on              = wb[`SHC_MC_ON_BIT];
          s_d.external_sensor_count  = wb[1:0];
        end
        `SHC_IDX_S1_TARGET:
        begin
          s_d.addr[0]  = wb[7:1];
          s_d.rd_en[0] = wb[0];
        end
        `SHC_IDX_S1_PTR:
        begin
          s_d.reg_ptr[0] = wb;
        end
        `SHC_IDX_S2_TARGET:
        begin
          s_d.addr[1]  = wb[7:1];
          s_d.rd_en[1] = wb[0];
        end
        `SHC_IDX_S2_PTR:
        begin
          s_d.reg_ptr[1] = wb;
        end
        `SHC_IDX_S2_CFG:
        begin
          // Upper four bits are not stored and read zero
          s_d.fifo_batch[1] = wb[`SHC_CFG_BATCH_BIT];
          s_d.read_count[1] = wb[2:0];
        end
        `SHC_IDX_S3_TARGET:
        begin
          s_d.addr[2]  = wb[7:1];
          s_d.rd_en[2] = wb[0];
        end
        `SHC_IDX_S3_PTR:
        begin
          s_d.reg_ptr[2] = wb;
        end
        `SHC_IDX_S3_CFG:
        begin
          s_d.fifo_batch[2] = wb[`SHC_CFG_BATCH_BIT];
          s_d.read_count[2] = wb[2:0];
        end
        `SHC_IDX_S4_TARGET:
        begin
          s_d.addr[3]  = wb[7:1];
          s_d.rd_en[3] = wb[0];
        end
        `SHC_IDX_S4_PTR:
        begin
          s_d.reg_ptr[3] = wb;
        end
        `SHC_IDX_S1_WDATA:
        begin
          s_d.sensor1_write_byte = wb;
        end
        default:
        begin
          // Status and unmapped words ignore writes
        end
      endcase
    end

    // Hub cycle sequencer
    case (s_q.fsm)
      shc_pkg::SHC_IDLE:
      begin
        if (s_q.master_on && hub_trigger)
        begin
          start           = 1'b1;
          s_d.slot        = 2'd0;
          s_d.fsm         = shc_pkg::SHC_SCAN;
        end
      end
      shc_pkg::SHC_SCAN:
      begin
        if (slot_active(s_q, s_q.slot))
        begin
          // Latch the request so the engine sees stable flop outputs
          s_d.req.slot       = s_q.slot;
          s_d.req.addr       = s_q.addr[s_q.slot];
          s_d.req.reg_ptr    = s_q.reg_ptr[s_q.slot];
          s_d.req.read       = (s_q.slot != 2'd0) | s_q.rd_en[0];
          s_d.req.count      = (s_q.slot == 2'd3) ? `SHC_S4_READS : s_q.read_count[s_q.slot];
          s_d.req.wdata      = s_q.sensor1_write_byte;
          s_d.req.fifo_batch = s_q.fifo_batch[s_q.slot];
          s_d.fsm            = shc_pkg::SHC_WAIT;
        end
        else if (last_slot(s_q))
        begin
          s_d.hub_cycle_done   = 1'b1;
          s_d.first_cycle_seen = 1'b1;
          s_d.fsm              = shc_pkg::SHC_IDLE;
        end
        else
        begin
          s_d.slot = s_q.slot + 2'd1;
        end
      end
      shc_pkg::SHC_WAIT:
      begin
        if (xfer_done)
        begin
          if (xfer_noack)
          begin
            s_d.noack[s_q.slot] = 1'b1;
          end
          else if (s_q.slot == 2'd0 && !s_q.req.read && s_q.first_cycle_write_only)
          begin
            s_d.single_write_complete = 1'b1;
          end
          if (last_slot(s_q))
          begin
            s_d.hub_cycle_done   = 1'b1;
            s_d.first_cycle_seen = 1'b1;
            s_d.fsm              = shc_pkg::SHC_IDLE;
          end
          else
          begin
            s_d.slot = s_q.slot + 2'd1;
            s_d.fsm  = shc_pkg::SHC_SCAN;
          end
        end
      end
      default:
      begin
        s_d.fsm = shc_pkg::SHC_IDLE;
      end
    endcase

    // A new hub cycle clears the cycle-done bit and the refusal flags
    if (start)
    begin
      s_d.hub_cycle_done = 1'b0;
      s_d.noack          = 4'h0;
    end

    // Turning the master off ends any cycle and re-arms first_cycle_write_only
    if (!s_q.master_on)
    begin
      s_d.fsm                   = shc_pkg::SHC_IDLE;
      s_d.first_cycle_seen      = 1'b0;
      s_d.single_write_complete = 1'b0;
    end

    // Capture the address phase of a selected transfer
    s_d.ap_valid = hsel && hready && htrans[1];
    s_d.ap.wr    = hwrite;
    s_d.ap.idx   = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'hFF;

    // Read data comes from the updated state so a write is seen at once
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      s_d.rdata = {24'h0, reg_read(s_d, s_d.ap.idx)};
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Whole state held in one register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Zero wait states, always OKAY; hsize accepted as any width
  assign hrdata        = s_q.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;

  // Engine side
  assign aux_master_en = s_q.master_on;
  assign req_valid     = (s_q.fsm == shc_pkg::SHC_WAIT);
  assign req           = s_q.req;

endmodule : shc_hub_cfg

`default_nettype wire

//--- shc_sensor_model.sv
/* Engine and sensors behind the hub: answers each request after a set wait.
   Assumes the req_valid / xfer_done handshake of shc_hub_cfg on hclk. */
`timescale 1ns/1ns
`default_nettype none
module shc_sensor_model (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // Request from the hub
  input  wire logic              req_valid,
  input  wire shc_pkg::shc_req_t req,
  // Wait length and refusals set by the bench
  input  wire logic [3:0]        dly,
  input  wire logic [3:0]        nack_mask,
  // Completion towards the hub
  output logic                   xfer_done,
  output logic                   xfer_noack
);
  logic [3:0] cnt_q;
  logic       fin;
  assign fin = req_valid && !xfer_done && cnt_q == dly;
  // Wait dly cycles, pulse done once; noack toggles when it means nothing
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt_q      <= 4'h0;
      xfer_done  <= 1'h0;
      xfer_noack <= 1'h0;
    end
    else
    begin
      xfer_done  <= fin;
      xfer_noack <= fin ? nack_mask[req.slot] : ~xfer_noack;
      cnt_q      <= (req_valid && !xfer_done && !fin) ? cnt_q + 4'h1 : 4'h0;
    end
endmodule : shc_sensor_model
`default_nettype wire

//--- shc_hub_cfg_assertions.sv
/* Checker for shc_hub_cfg: bus answers, engine handshake, reset state.
   Assumes it is bound to shc_hub_cfg and sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module shc_hub_cfg_assertions (
  // Clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // Register bus
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Engine link
  input wire logic              aux_master_en,
  input wire logic              req_valid,
  input wire shc_pkg::shc_req_t req,
  input wire logic              xfer_done
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Steps of a bus read and of an engine request
  sequence s_rd_ap; hsel && hready && htrans[1] && !hwrite; endsequence
  sequence s_wait; req_valid && !xfer_done; endsequence
  sequence s_end; req_valid && xfer_done; endsequence
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("slave not ready");
  property p_rst; $rose(hresetn) |-> !req_valid && !aux_master_en && hrdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_rd_upper; s_rd_ap |=> hrdata[31:8] == 24'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read upper bits set");
  property p_rd_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_req_hold; s_wait |=> req_valid && $stable(req); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_release; s_end |=> !req_valid; endproperty
  a_release: assert property (p_release) else $error("request kept");
  property p_read_only; req_valid && req.slot != 2'h0 |-> req.read; endproperty
  a_read_only: assert property (p_read_only) else $error("write to read slot");
  property p_slot4; req_valid && req.slot == 2'h3 |-> req.count == 3'h1 && !req.fifo_batch; endproperty
  a_slot4: assert property (p_slot4) else $error("bad sensor 4 request");
  property p_gate; $rose(req_valid) |-> aux_master_en; endproperty
  a_gate: assert property (p_gate) else $error("request while off");
endmodule : shc_hub_cfg_assertions
bind shc_hub_cfg shc_hub_cfg_assertions shc_hub_cfg_assertions_inst (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .aux_master_en, .req_valid, .req, .xfer_done);
`default_nettype wire

//--- shc_hub_cfg_tb.sv
/* Bench for shc_hub_cfg: AHB-Lite master, register image and hub cycle model.
   Assumes shc_sensor_model answers on the engine side. */
`timescale 1ns/1ns
`default_nettype none
`include "shc_params.svh"
module shc_hub_cfg_tb;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic              hclk = 1'h0;
  logic              hresetn = 1'h0;
  logic              hsel = 1'h0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'h0;
  logic [31:0]       hwdata = 32'h0;
  logic              hub_trigger = 1'h0;
  logic [3:0]        dly = 4'h0;
  logic [3:0]        nack_mask = 4'h0;
  logic              seen = 1'h0;
  logic [31:0]       hrdata, rd;
  logic              hreadyout, hresp, aux_master_en, req_valid, xfer_done, xfer_noack;
  shc_pkg::shc_req_t req;
  shc_pkg::shc_req_t got_q[$];
  logic [7:0]        m [0:255] = '{default: 8'h00};
  int                fail_count = 0;
  int                checked = 0;
  // Clock
  always #20 hclk = ~hclk;
  // Design and partner
  shc_hub_cfg shc_hub_cfg_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .hub_trigger, .aux_master_en, .req_valid, .req,
    .xfer_done, .xfer_noack);
  shc_sensor_model shc_sensor_model_inst (.hclk, .hresetn, .req_valid, .req, .dly, .nack_mask,
    .xfer_done, .xfer_noack);
  // Collect every finished request
  always @(posedge hclk)
    if (req_valid && xfer_done)
      got_q.push_back(req);
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : bus
  // Bits each index stores
  function automatic logic [7:0] msk(input logic [7:0] i);
    if (i == 8'h14) return 8'h47;
    if (i == 8'h1A || i == 8'h1D) return 8'h0F;
    return (i inside {8'h15, 8'h16, [8'h18:8'h1F], 8'h21}) ? 8'hFF : 8'h00;
  endfunction : msk
  // Register write with image update
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    if (i == 8'h1A || i == 8'h1D) v[7:4] = 4'h0;
    bus(1'h1, i, {24'h0, v});
    m[i] = m[i] & ~msk(i) | v & msk(i);
    if (i == 8'h14 && !v[2])
    begin
      m[8'h22][7] = 1'h0;
      seen = 1'h0;
    end
  endtask : wr
  // Register read against the image
  task automatic rdc(input logic [7:0] i);
    bus(1'h0, i, 32'h0);
    chk(rd, {24'h0, m[i]});
  endtask : rdc
  // One hub cycle: trigger, wait for its end, compare requests and status
  task automatic cyc();
    shc_pkg::shc_req_t g;
    logic [7:0] stat, t, f;
    logic act, any;
    stat = {m[8'h22][7], 7'h01};
    any = 1'h0;
    got_q.delete();
    hub_trigger <= 1'h1;
    @(posedge hclk);
    hub_trigger <= 1'h0;
    bus(1'h0, `SHC_IDX_STATUS, 32'h0);
    f = rd[7:0];
    while (rd[0] !== 1'h1) bus(1'h0, `SHC_IDX_STATUS, 32'h0);
    for (int s = 0; s <= m[8'h14][1:0]; s++)
    begin
      t = 8'h15 + 8'(3 * s);
      act = s == 0 ? m[8'h15][0] || !(m[8'h14][6] && seen) : m[t][0];
      any |= act;
      if (act)
      begin
        chk(32'(got_q.size() != 0), 32'h1);
        g = got_q.pop_front();
        chk({g.slot, g.addr, g.reg_ptr, g.read}, {2'(s), m[t][7:1], m[t + 8'h1], s != 0 || m[8'h15][0]});
        if (s == 1 || s == 2) chk({g.count, g.fifo_batch}, {m[t + 8'h2][2:0], m[t + 8'h2][3]});
        if (s == 3) chk({g.count, g.fifo_batch}, 4'h2);
        if (s == 0 && !m[8'h15][0]) chk(g.wdata, m[8'h21]);
        // A refused sensor 1 write does not count as a completed write
        if (s == 0 && !m[8'h15][0] && m[8'h14][6] && !nack_mask[0]) stat[7] = 1'h1;
        stat[3 + s] = nack_mask[s];
      end
    end
    chk(32'(got_q.size()), 32'h0);
    chk(rd, {24'h0, stat});
    if (any && dly > 4'h4) chk(f[0], 1'h0);
    m[8'h22] = stat;
    seen = 1'h1;
  endtask : cyc
  // Verdict and end of run
  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // Main sequence
  initial
  begin
    void'($urandom(99507));
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    for (int i = 8'h10; i < 8'h28; i++) rdc(8'(i));
    for (int i = 8'h10; i < 8'h28; i++) wr(8'(i), 8'($urandom));
    for (int i = 8'h10; i < 8'h28; i++) rdc(8'(i));
    for (int k = 0; k < 24; k++)
    begin
      if (k == 12)
      begin
        wr(8'h14, 8'h00);
        hub_trigger <= 1'h1;
        @(posedge hclk);
        hub_trigger <= 1'h0;
        repeat (4) @(posedge hclk);
        chk({aux_master_en, req_valid}, 2'h0);
        rdc(8'h22);
      end
      for (int i = 8'h15; i < 8'h22; i++) wr(8'(i), 8'($urandom));
      wr(8'h14, 8'($urandom) | 8'h04);
      nack_mask <= 4'($urandom);
      dly <= 4'($urandom % 8);
      cyc();
    end
    stop_test();
  end
  // Watchdog
  initial
  begin
    #(40 * 20000);
    fail_count++;
    stop_test();
  end
endmodule : shc_hub_cfg_tb
`default_nettype wire
